// >>> inc/iars_pkg.sv
/*
  constants, field layouts and carrier types for the i/o area read service handler.
  assumes one system clock and one active-high asynchronous reset.
*/
package iars_pkg;

  // service codes
  localparam logic [7:0]  SVC_READ       = 8'h4b;
  localparam logic [7:0]  SVC_OK         = 8'hcb;
  localparam logic [7:0]  SVC_ERR        = 8'h94;

  // object addressing
  localparam logic [15:0] CLASS_IO       = 16'h0306;
  localparam logic [15:0] INST_LIN       = 16'h0001;
  localparam logic [15:0] INST_LOUT      = 16'h0002;
  localparam logic [15:0] INST_RIN       = 16'h0005;
  localparam logic [15:0] INST_ROUT      = 16'h0006;

  // response codes, general byte high, additional byte low; ERR_LEN is the error reply length in bytes
  localparam logic [15:0] ERR_NONE       = 16'h0000;
  localparam logic [15:0] ERR_SVC        = 16'h08ff;
  localparam logic [15:0] ERR_SHORT      = 16'h13ff;
  localparam logic [15:0] ERR_LONG       = 16'h15ff;
  localparam logic [15:0] ERR_OBJ        = 16'h16ff;
  localparam logic [15:0] ERR_PARAM      = 16'h20ff;
  localparam logic [15:0] ERR_LEN        = 16'h0002;

  // request data field: offset and count, two bytes each
  localparam logic [8:0]  RD_DATA_LEN    = 9'h004;
  localparam logic [15:0] CNT_MIN        = 16'h0001;
  localparam logic [15:0] CNT_MAX        = 16'h0030;

  // area sizes and highest start offsets
  localparam logic [15:0] LIN_LEN        = 16'h0006;
  localparam logic [15:0] LOUT_LEN       = 16'h0002;
  localparam int          RMT_LEN        = 512;
  localparam logic [15:0] LIN_OFS_LARGE  = 16'h0005;
  localparam logic [15:0] LIN_OFS_SMALL  = 16'h0001;
  localparam logic [15:0] LOUT_OFS_MAX   = 16'h0001;
  localparam logic [15:0] RMT_OFS_MAX    = 16'h01ff;

  // terminals present on the small variant
  localparam logic [39:0] SMALL_IN_MASK  = 40'h00_0000_ffff;
  localparam logic [7:0]  SMALL_TEST_MASK = 8'h0f;

  // reset values
  localparam logic [15:0] IDX_RST        = 16'h0000;
  localparam logic [7:0]  BYTE_RST       = 8'h00;

  typedef enum logic [1:0] {AREA_LIN, AREA_LOUT, AREA_RIN, AREA_ROUT} iars_area_type;

  typedef struct packed {
    logic [7:0]  svc;       // service code
    logic [15:0] cls;       // object class
    logic [15:0] inst;      // instance
    logic [8:0]  decl_len;  // data size the request declares
    logic [8:0]  data_len;  // data bytes actually received
    logic [15:0] offset;    // start byte
    logic [15:0] count;     // bytes to read
  } iars_req_type;

  typedef struct packed {
    logic        we;        // write strobe
    logic        sel;       // 0 remote input area, 1 remote output area
    logic [8:0]  addr;      // byte address
    logic [7:0]  data;      // byte value
  } iars_rmt_wr_type;

  typedef struct packed {
    logic [7:0]  svc;       // reply service code
    logic [7:0]  data;      // payload byte
    logic        last;      // final payload byte
  } iars_rsp_type;

endpackage

// >>> rtl/iars_sync3.sv
/*
  three-stage synchroniser for a bus of pin levels; a change is taken once
  the second and third stages agree.
  assumes inputs asynchronous to ref_clk_i.
*/
`timescale 1ns/100ps
module iars_sync3 #(
  parameter int W = 8
) (
  input  wire logic         ref_clk_i, // system clock
  input  wire logic         rst_i,     // async reset, active high
  input  wire logic [W-1:0] d_i,       // raw pin levels
  output logic      [W-1:0] q_o        // filtered levels
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  always_comb begin
    next_q = q_o;
    for (int b = 0; b < W; b++) begin
      if (s2[b] == s3[b]) begin
        next_q[b] = s3[b];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1  <= '0;
      s2  <= '0;
      s3  <= '0;
      q_o <= '0;
    end else begin
      s1  <= d_i;
      s2  <= s1;
      s3  <= s2;
      q_o <= next_q;
    end
  end

endmodule // iars_sync3

// >>> rtl/iars_top.sv
/*
  i/o area read service handler: takes one read request, checks it, and
  streams back either the selected area bytes or a two-byte error.
  assumes requests already deframed; remote areas written by the i/o engine.
*/
// Behaviour
// - every accepted request yields exactly one response stream.
// - read requests use code 4b; success replies carry cb.
// - only class 0306 with a known instance is served, else 16ff.
// - instance 0001 reads local inputs, 0002 reads local outputs.
// - instance 0005 reads remote inputs, 0006 reads remote outputs.
// - offset is the first byte read, counted from area start.
// - success payload is the requested bytes from the offset onward.
// - input image six bytes; bytes 2 and 5 carry four states.
// - small variant shows inputs 0..15, large shows 0..39.
// - output image: byte 0 safety outputs, byte 1 test outputs.
// - small variant shows test outputs 0..3, large shows 0..7.
// - unknown service code answered with 08ff.
// - data shorter than declared answered with 13ff.
// - data longer than declared answered with 15ff.
// - count or offset outside supported values answered with 20ff.
// - error replies carry code 94 and two error bytes.
`timescale 1ns/100ps
module iars_top
  import iars_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic                      ref_clk_i,     // system clock, 10 mhz
  input  wire logic                      rst_i,         // async reset, active high
  input  wire logic                      req_valid_i,   // request present
  input  wire iars_pkg::iars_req_type    req_i,         // request fields
  output logic                           req_ready_o,   // request taken when high
  input  wire logic [39:0]               local_in_i,    // safety input terminals
  input  wire logic [7:0]                safety_out_i,  // safety output terminals
  input  wire logic [7:0]                test_out_i,    // test output terminals
  input  wire iars_pkg::iars_rmt_wr_type rmt_wr_i,      // remote area write
  output logic                           rsp_valid_o,   // response byte present
  output iars_pkg::iars_rsp_type         rsp_o,         // response byte and code
  input  wire logic                      rsp_ready_i    // sink takes byte
);
  import iars_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_SEND} iars_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and area storage

  logic [39:0] in_q;
  logic [15:0] out_q;
  logic [7:0]  rin_mem  [RMT_LEN];
  logic [7:0]  rout_mem [RMT_LEN];

  iars_sync3 #(.W(40)) u_sync_in (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (local_in_i),
    .q_o       (in_q)
  );

  iars_sync3 #(.W(16)) u_sync_out (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       ({test_out_i, safety_out_i}),
    .q_o       (out_q)
  );

  always_ff @(posedge ref_clk_i) begin
    if (rmt_wr_i.we && !rmt_wr_i.sel) begin
      rin_mem[rmt_wr_i.addr] <= rmt_wr_i.data;
    end
    if (rmt_wr_i.we && rmt_wr_i.sel) begin
      rout_mem[rmt_wr_i.addr] <= rmt_wr_i.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  iars_state_type state;
  iars_req_type   req;
  iars_area_type  area;
  logic [15:0]    err;
  logic [15:0]    idx;
  logic [15:0]    len;
  logic           req_ready;
  logic           rsp_valid;
  iars_rsp_type   rsp;

  iars_state_type next_state;
  iars_req_type   next_req;
  iars_area_type  next_area;
  logic [15:0]    next_err;
  logic [15:0]    next_idx;
  logic [15:0]    next_len;
  logic           next_req_ready;
  logic           next_rsp_valid;
  iars_rsp_type   next_rsp;

  ////////////////////////////////////////////////////////////////////////////
  // request checks

  iars_area_type chk_area;
  logic [15:0]   chk_err;
  logic [15:0]   ofs_max;
  logic          obj_ok;

  always_comb begin
    chk_area = AREA_LIN;
    ofs_max  = LOUT_OFS_MAX;
    obj_ok   = 1'b1;
    case (req.inst)
      INST_LIN: begin
        chk_area = AREA_LIN;
        ofs_max  = LARGE_VARIANT ? LIN_OFS_LARGE : LIN_OFS_SMALL;
      end
      INST_LOUT: begin
        chk_area = AREA_LOUT;
        ofs_max  = LOUT_OFS_MAX;
      end
      INST_RIN: begin
        chk_area = AREA_RIN;
        ofs_max  = RMT_OFS_MAX;
      end
      INST_ROUT: begin
        chk_area = AREA_ROUT;
        ofs_max  = RMT_OFS_MAX;
      end
      default: begin
        obj_ok = 1'b0;
      end
    endcase
    // first failing check wins
    if (req.svc != SVC_READ) begin
      chk_err = ERR_SVC;
    end else if (req.cls != CLASS_IO || !obj_ok) begin
      chk_err = ERR_OBJ;
    end else if (req.data_len < req.decl_len || req.data_len < RD_DATA_LEN) begin
      chk_err = ERR_SHORT;
    end else if (req.data_len > req.decl_len || req.data_len > RD_DATA_LEN) begin
      chk_err = ERR_LONG;
    end else if (req.count < CNT_MIN || req.count > CNT_MAX || req.offset > ofs_max) begin
      chk_err = ERR_PARAM;
    end else begin
      chk_err = ERR_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte fetch

  logic [47:0]   lin_img;
  logic [47:0]   lin_sh;
  logic [39:0]   in_vis;
  logic [7:0]    test_vis;
  iars_area_type fetch_area;
  logic [15:0]   fetch_idx;
  logic [15:0]   fetch_addr;
  logic [7:0]    fetch_byte;

  always_comb begin
    in_vis   = LARGE_VARIANT ? in_q : (in_q & SMALL_IN_MASK);
    test_vis = LARGE_VARIANT ? out_q[15:8] : (out_q[15:8] & SMALL_TEST_MASK);
    // upper nibbles of bytes 2 and 5 are reserved
    lin_img  = {4'h0, in_vis[39:36], in_vis[35:28], in_vis[27:20],
                4'h0, in_vis[19:16], in_vis[15:8], in_vis[7:0]};
    fetch_area = (state == ST_SEND) ? area : chk_area;
    fetch_idx  = (state == ST_SEND) ? 16'(idx + 16'h0001) : IDX_RST;
    fetch_addr = 16'(req.offset + fetch_idx);
    lin_sh     = lin_img >> {fetch_addr[2:0], 3'b000};
    fetch_byte = BYTE_RST;
    case (fetch_area)
      AREA_LIN: begin
        if (fetch_addr < LIN_LEN) begin
          fetch_byte = lin_sh[7:0];
        end
      end
      AREA_LOUT: begin
        if (fetch_addr < LOUT_LEN) begin
          fetch_byte = fetch_addr[0] ? test_vis : out_q[7:0];
        end
      end
      AREA_RIN: begin
        if (32'(fetch_addr) < RMT_LEN) begin
          fetch_byte = rin_mem[fetch_addr[8:0]];
        end
      end
      AREA_ROUT: begin
        if (32'(fetch_addr) < RMT_LEN) begin
          fetch_byte = rout_mem[fetch_addr[8:0]];
        end
      end
      default: begin
        fetch_byte = BYTE_RST;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    next_state     = state;
    next_req       = req;
    next_area      = area;
    next_err       = err;
    next_idx       = idx;
    next_len       = len;
    next_req_ready = req_ready;
    next_rsp_valid = rsp_valid;
    next_rsp       = rsp;
    case (state)
      ST_IDLE: begin
        if (req_valid_i && req_ready) begin
          next_req       = req_i;
          next_req_ready = 1'b0;
          next_state     = ST_EVAL;
        end
      end
      ST_EVAL: begin
        next_err  = chk_err;
        next_area = chk_area;
        next_idx  = IDX_RST;
        if (chk_err != ERR_NONE) begin
          next_len      = ERR_LEN;
          next_rsp.svc  = SVC_ERR;
          next_rsp.data = chk_err[15:8];
          next_rsp.last = 1'b0;
        end else begin
          next_len      = req.count;
          next_rsp.svc  = SVC_OK;
          next_rsp.data = fetch_byte;
          next_rsp.last = (req.count == CNT_MIN);
        end
        next_rsp_valid = 1'b1;
        next_state     = ST_SEND;
      end
      ST_SEND: begin
        if (rsp_ready_i) begin
          if (rsp.last) begin
            next_rsp_valid = 1'b0;
            next_req_ready = 1'b1;
            next_state     = ST_IDLE;
          end else begin
            next_idx      = 16'(idx + 16'h0001);
            next_rsp.data = (err != ERR_NONE) ? err[7:0] : fetch_byte;
            next_rsp.last = (16'(idx + 16'h0002) == len);
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state     <= ST_IDLE;
      req       <= '0;
      area      <= AREA_LIN;
      err       <= ERR_NONE;
      idx       <= IDX_RST;
      len       <= IDX_RST;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      state     <= next_state;
      req       <= next_req;
      area      <= next_area;
      err       <= next_err;
      idx       <= next_idx;
      len       <= next_len;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp       <= next_rsp;
    end
  end

  assign req_ready_o = req_ready;
  assign rsp_valid_o = rsp_valid;
  assign rsp_o       = rsp;

endmodule // iars_top

// >>> bench/iars_chk_chk.sv
/* port checker for the area read handler.
   assumes it is bound onto iars_top, one clock. */
`timescale 1ns/100ps
module iars_chk
  import iars_pkg::*;
#(parameter bit LARGE_VARIANT = 1'b1) (
  input wire logic                      ref_clk_i,    // clock
  input wire logic                      rst_i,        // reset
  input wire logic                      req_valid_i,  // request
  input wire iars_pkg::iars_req_type    req_i,        // fields
  input wire logic                      req_ready_o,  // idle
  input wire logic [39:0]               local_in_i,   // pins
  input wire logic [7:0]                safety_out_i, // pins
  input wire logic [7:0]                test_out_i,   // pins
  input wire iars_pkg::iars_rmt_wr_type rmt_wr_i,     // remote write
  input wire logic                      rsp_valid_o,  // byte present
  input wire iars_pkg::iars_rsp_type    rsp_o,        // byte
  input wire logic                      rsp_ready_i   // sink ready
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire acc = req_valid_i && req_ready_o;
  wire svc = req_i.svc == SVC_READ;
  wire obj = req_i.cls == CLASS_IO && req_i.inst inside {INST_LIN, INST_LOUT, INST_RIN, INST_ROUT};
  wire lok = req_i.data_len == req_i.decl_len && req_i.data_len == RD_DATA_LEN;
  wire cok = req_i.count inside {[CNT_MIN:CNT_MAX]};
  wire lin_bad = req_i.inst == INST_LIN && req_i.offset > (LARGE_VARIANT ? LIN_OFS_LARGE : LIN_OFS_SMALL);
  property p_answer; acc |=> !req_ready_o ##1 rsp_valid_o; endproperty
  a_answer: assert property (p_answer) else $error("no reply after accept");
  property p_ok; acc && svc && obj && lok && cok && req_i.offset == 16'h0 |-> ##2 rsp_o.svc == SVC_OK; endproperty
  a_ok: assert property (p_ok) else $error("good read not answered with ok code");
  property p_svc; acc && !svc |-> ##2 rsp_o.svc == SVC_ERR && rsp_o.data == ERR_SVC[15:8]; endproperty
  a_svc: assert property (p_svc) else $error("bad service code not refused");
  property p_obj; acc && svc && !obj |-> ##2 rsp_o.data == ERR_OBJ[15:8]; endproperty
  a_obj: assert property (p_obj) else $error("bad object not refused");
  property p_short;
    acc && svc && obj && (req_i.data_len < req_i.decl_len || req_i.data_len < RD_DATA_LEN)
      |-> ##2 rsp_o.data == ERR_SHORT[15:8];
  endproperty
  a_short: assert property (p_short) else $error("short data not refused");
  property p_long;
    acc && svc && obj && req_i.data_len >= req_i.decl_len && req_i.data_len >= RD_DATA_LEN && !lok
      |-> ##2 rsp_o.data == ERR_LONG[15:8];
  endproperty
  a_long: assert property (p_long) else $error("long data not refused");
  property p_range; acc && svc && obj && lok && (!cok || lin_bad) |-> ##2 rsp_o.data == ERR_PARAM[15:8]; endproperty
  a_range: assert property (p_range) else $error("bad range not refused");
  property p_err2;
    rsp_valid_o && rsp_o.svc == SVC_ERR && !rsp_o.last && rsp_ready_i |=> rsp_valid_o && rsp_o.last && rsp_o.data == 8'hff;
  endproperty
  a_err2: assert property (p_err2) else $error("error reply not two bytes");
  property p_hold; rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_o); endproperty
  a_hold: assert property (p_hold) else $error("reply byte moved while stalled");
endmodule // iars_chk
bind iars_top iars_chk #(.LARGE_VARIANT(LARGE_VARIANT)) chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .local_in_i(local_in_i),
  .safety_out_i(safety_out_i), .test_out_i(test_out_i), .rmt_wr_i(rmt_wr_i), .rsp_valid_o(rsp_valid_o),
  .rsp_o(rsp_o), .rsp_ready_i(rsp_ready_i));

// >>> bench/iars_master.sv
/* master model: issues one read request, collects the reply bytes.
   assumes one outstanding request at the handler. */
`timescale 1ns/100ps
module iars_master
  import iars_pkg::*;
(
  input  wire logic                   ref_clk_i,   // clock
  output logic                        req_valid_o, // request present
  output iars_pkg::iars_req_type      req_o,       // request fields
  input  wire logic                   req_ready_i, // request taken
  input  wire logic                   rsp_valid_i, // byte present
  input  wire iars_pkg::iars_rsp_type rsp_i,       // reply byte
  output logic                        rsp_ready_o  // byte taken
);
  logic [7:0] got[$];
  logic [7:0] got_svc;
  bit         tmo;
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
    rsp_ready_o = 1'b1;
  end
  task automatic send(input iars_req_type r, input int stall);
    int k;
    got.delete();
    tmo = 1'b1;
    @(posedge ref_clk_i);
    #1;
    req_valid_o = 1'b1;
    req_o = r;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (req_ready_i !== 1'b1 && k < 50);
    #1;
    req_valid_o = 1'b0;
    req_o = ~r; // released fields show no stale value
    rsp_ready_o = (stall == 0);
    for (k = 1; k < 300; k++) begin
      @(posedge ref_clk_i);
      if (rsp_valid_i === 1'b1 && rsp_ready_o === 1'b1) begin
        got.push_back(rsp_i.data);
        got_svc = rsp_i.svc;
        if (rsp_i.last === 1'b1) begin
          tmo = 1'b0;
          break;
        end
      end
      #1;
      rsp_ready_o = (stall == 0) || (k % stall == 0);
    end
  endtask
endmodule // iars_master

// >>> bench/test_io_area_read_service.sv
/* self-checking bench for the area read handler.
   assumes the master model and checker compile first. */
`timescale 1ns/100ps
module test_io_area_read_service;
  import iars_pkg::*;
  logic            ref_clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            req_valid, req_ready, rsp_valid, rsp_ready;
  iars_req_type    req;
  iars_rsp_type    rsp;
  logic            req_valid_s, req_ready_s, rsp_valid_s, rsp_ready_s;
  iars_req_type    req_s;
  iars_rsp_type    rsp_s;
  logic [39:0]     pin_in = 40'h0;
  logic [7:0]      pin_safe = 8'h0;
  logic [7:0]      pin_test = 8'h0;
  iars_rmt_wr_type wr = '0;
  int              n_fail = 0;
  int              checked = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  iars_top dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid), .req_i(req),
    .req_ready_o(req_ready), .local_in_i(pin_in), .safety_out_i(pin_safe), .test_out_i(pin_test),
    .rmt_wr_i(wr), .rsp_valid_o(rsp_valid), .rsp_o(rsp), .rsp_ready_i(rsp_ready));
  iars_master master_u (.ref_clk_i(ref_clk_i), .req_valid_o(req_valid), .req_o(req),
    .req_ready_i(req_ready), .rsp_valid_i(rsp_valid), .rsp_i(rsp), .rsp_ready_o(rsp_ready));
  // 16-input variant watching the same pins
  iars_top #(.LARGE_VARIANT(1'b0)) dut_small_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_s),
    .req_i(req_s), .req_ready_o(req_ready_s), .local_in_i(pin_in), .safety_out_i(pin_safe), .test_out_i(pin_test),
    .rmt_wr_i(wr), .rsp_valid_o(rsp_valid_s), .rsp_o(rsp_s), .rsp_ready_i(rsp_ready_s));
  iars_master small_u (.ref_clk_i(ref_clk_i), .req_valid_o(req_valid_s), .req_o(req_s),
    .req_ready_i(req_ready_s), .rsp_valid_i(rsp_valid_s), .rsp_i(rsp_s), .rsp_ready_o(rsp_ready_s));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic iars_req_type rd(logic [15:0] inst, logic [15:0] ofs, logic [15:0] cnt);
    rd = '{SVC_READ, CLASS_IO, inst, RD_DATA_LEN, RD_DATA_LEN, ofs, cnt};
  endfunction
  task automatic judge(input bit tmo, input logic [7:0] gsvc, input logic [7:0] got[$],
                       input logic [7:0] svc, input logic [7:0] exp[$]);
    if (tmo) begin
      n_fail++;
      report_and_stop();
    end
    chk(16'(gsvc), 16'(svc));
    chk(16'(got.size()), 16'(exp.size()));
    foreach (exp[i]) chk(16'(got[i]), 16'(exp[i]));
  endtask
  task automatic xfer(input iars_req_type r, input int stall, input logic [7:0] svc, input logic [7:0] exp[$]);
    master_u.send(r, stall);
    judge(master_u.tmo, master_u.got_svc, master_u.got, svc, exp);
  endtask
  task automatic xe(input iars_req_type r, input logic [15:0] code);
    xfer(r, 0, SVC_ERR, '{code[15:8], code[7:0]});
  endtask
  task automatic wr_byte(input logic sel, input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    wr = '{1'b1, sel, a, d};
    @(posedge ref_clk_i);
    #1;
    wr = '0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_errors();
    iars_req_type r;
    r = rd(INST_LIN, 16'h0, 16'h1);
    r.svc = 8'h4c;
    r.cls = 16'h0307;
    xe(r, ERR_SVC);
    r = rd(INST_LIN, 16'h0, 16'h0);
    r.cls = 16'h0307;
    xe(r, ERR_OBJ);
    xe(rd(16'h0003, 16'h0, 16'h1), ERR_OBJ);
    r = rd(INST_RIN, 16'h0, 16'h0);
    r.data_len = 9'h003;
    xe(r, ERR_SHORT);
    r = rd(INST_RIN, 16'h0, 16'h1);
    r.data_len = 9'h005;
    xe(r, ERR_LONG);
    r.data_len = RD_DATA_LEN;
    r.decl_len = 9'h003;
    xe(r, ERR_LONG);
    xe(rd(INST_ROUT, 16'h0, 16'h0), ERR_PARAM);
    xe(rd(INST_ROUT, 16'h0, 16'h0031), ERR_PARAM);
    xe(rd(INST_LIN, 16'h0006, 16'h1), ERR_PARAM);
    xe(rd(INST_RIN, 16'h0200, 16'h1), ERR_PARAM);
    $display("test errors done");
  endtask
  task automatic t_local();
    logic [7:0] img[$];
    @(posedge ref_clk_i);
    #1;
    pin_in = 40'hda_5c3f_e7b6;
    pin_safe = 8'h3c;
    pin_test = 8'ha5;
    repeat (6) @(posedge ref_clk_i);
    img = '{pin_in[7:0], pin_in[15:8], {4'h0, pin_in[19:16]}, pin_in[27:20], pin_in[35:28], {4'h0, pin_in[39:36]}};
    xfer(rd(INST_LIN, 16'h0, 16'h6), 0, SVC_OK, img);
    xfer(rd(INST_LIN, 16'h5, 16'h1), 0, SVC_OK, img[5:5]);
    xfer(rd(INST_LOUT, 16'h0, 16'h2), 3, SVC_OK, '{8'h3c, 8'ha5});
    xfer(rd(INST_LOUT, 16'h1, 16'h1), 0, SVC_OK, '{8'ha5});
    $display("test local done");
  endtask
  task automatic t_remote();
    wr_byte(1'b0, 9'h1fe, 8'h11);
    wr_byte(1'b0, 9'h1ff, 8'h22);
    wr_byte(1'b1, 9'h000, 8'h33);
    wr_byte(1'b1, 9'h001, 8'h44);
    xfer(rd(INST_RIN, 16'h01fe, 16'h2), 0, SVC_OK, '{8'h11, 8'h22});
    xfer(rd(INST_ROUT, 16'h0, 16'h2), 2, SVC_OK, '{8'h33, 8'h44});
    $display("test remote done");
  endtask
  task automatic t_small();
    logic [7:0] img[$];
    logic [7:0] oimg[$];
    logic [7:0] eimg[$];
    // pins still hold the pattern set by the local test
    img = '{pin_in[7:0], pin_in[15:8], 8'h00, 8'h00, 8'h00, 8'h00};
    oimg = '{pin_safe, pin_test & 8'h0f};
    eimg = '{ERR_PARAM[15:8], ERR_PARAM[7:0]};
    small_u.send(rd(INST_LIN, 16'h0, 16'h6), 0);
    judge(small_u.tmo, small_u.got_svc, small_u.got, SVC_OK, img);
    small_u.send(rd(INST_LOUT, 16'h0, 16'h2), 0);
    judge(small_u.tmo, small_u.got_svc, small_u.got, SVC_OK, oimg);
    small_u.send(rd(INST_LIN, 16'h2, 16'h1), 0);
    judge(small_u.tmo, small_u.got_svc, small_u.got, SVC_ERR, eimg);
    $display("test small done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    chk({15'h0, req_ready}, 16'h1);
    chk({15'h0, rsp_valid}, 16'h0);
    chk({15'h0, req_ready_s}, 16'h1);
    t_errors();
    t_local();
    t_remote();
    t_small();
    report_and_stop();
  end
endmodule // test_io_area_read_service
